// ---- shared/synth_map.svh ----
`ifndef SYNTH_MAP_SVH
`define SYNTH_MAP_SVH

// Register byte addresses on the AXI4-Lite port
`define CTRL_ADDR      8'h00
`define STAT_ADDR      8'h04
`define PRESET_ADDR    8'h08
`define IRQ_STAT_ADDR  8'h0c
`define IRQ_CLR_ADDR   8'h10
`define IRQ_EN_ADDR    8'h14

// Control register fields and reset value
`define CTRL_LONG_BIT  0
`define CTRL_FINE_BIT  1
`define CTRL_W         2
`define CTRL_RST       2'h0

// Interrupt status bits
`define IRQ_LOAD_BIT   0
`define IRQ_LOCK_BIT   1
`define IRQ_UNLOCK_BIT 2
`define IRQ_W          3
`define IRQ_RST        3'h0

// AXI write response codes
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

// Serial word layout, swallow field in the low bits
`define SWORD_W        19
`define SWAL_W         5
`define SWAL_LSB       0
`define MAIN_LSB       5
`define MAIN_W         10
`define MAIN_W_SHORT   9
`define BAND_W         4
`define BAND_LSB_LONG  15
`define BAND_LSB_SHORT 14

// Reference divider: last count of 2^9-1 or 2^10-1
`define REF_W          10
`define REF_LAST_STD   10'h1ff
`define REF_LAST_FINE  10'h3ff
`define REF_MSB_STD    8
`define REF_MSB_FINE   9

// Fixed prescaler and dual modulus stage
`define RF_CNT_W       8
`define PRE_LAST       3'h7
`define RF_TAP_256     7
`define MOD_W          6
`define MOD_LAST_32    6'h1f
`define MOD_LAST_33    6'h20

// Lock window: largest pump pulse, in clock cycles
`define ERR_W          8
`define LOCK_WIN       8'h04

`endif

// ---- shared/synth_pkg.sv ----
package synth_pkg;

  // Operating mode decoded from the test, enable and lock pins
  typedef enum logic [1:0]
  {
    M_NORMAL,
    M_TEST1,
    M_TEST2,
    M_TEST3
  } mode_t;

endpackage

// ---- rtl/pin_sync.sv ----
// Two-stage synchroniser with edge detection on the settled copy
module pin_sync
(
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  input  wire logic i_pin,
  output logic      o_level,
  output logic      o_rise,
  output logic      o_fall
);

  logic meta_q;  // First stage, read only by lvl_q
  logic lvl_q;   // Settled level
  logic prev_q;  // Level one cycle older, for edges

  // Sampling chain; reset to low like an open input
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_q <= 1'b0;
      lvl_q  <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= i_pin;
      lvl_q  <= meta_q;
      prev_q <= lvl_q;
    end
  end

  assign o_level = lvl_q;
  assign o_rise  = lvl_q & ~prev_q;
  assign o_fall  = ~lvl_q & prev_q;

endmodule

// ---- rtl/synth_core.sv ----
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`include "synth_map.svh"

module synth_core
  import synth_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [7:0]  i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  input  wire logic        i_test_sel,
  input  wire logic        i_load_en,
  input  wire logic        i_sclk,
  output logic             o_sclk,
  output logic             o_sclk_oe_n,
  input  wire logic        i_sdata,
  output logic             o_sdata,
  output logic             o_sdata_oe_n,
  input  wire logic        i_lock,
  output logic             o_lock,
  output logic             o_lock_oe_n,
  input  wire logic        i_rf,
  input  wire logic        i_bypass,
  output logic             o_pump,
  output logic             o_pump_oe_n,
  output logic [3:0]       o_band,
  output logic             o_irq
);

  // Reset release through two flops
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Synchronised pins; only edges and levels leave these
  logic test_s;
  logic en_s;
  logic en_fall;
  logic sclk_s;
  logic sclk_rise;
  logic sdata_s;
  logic sdata_rise;
  logic lock_s;
  logic rf_rise;
  logic byp_rise;

  pin_sync u_test (.i_clock(i_clock), .i_rst_n(rst_n_q), .i_pin(i_test_sel),
    .o_level(test_s), .o_rise(), .o_fall());
  pin_sync u_en (.i_clock(i_clock), .i_rst_n(rst_n_q), .i_pin(i_load_en),
    .o_level(en_s), .o_rise(), .o_fall(en_fall));
  pin_sync u_sclk (.i_clock(i_clock), .i_rst_n(rst_n_q), .i_pin(i_sclk),
    .o_level(sclk_s), .o_rise(sclk_rise), .o_fall());
  pin_sync u_sdata (.i_clock(i_clock), .i_rst_n(rst_n_q), .i_pin(i_sdata),
    .o_level(sdata_s), .o_rise(sdata_rise), .o_fall());
  pin_sync u_lock (.i_clock(i_clock), .i_rst_n(rst_n_q), .i_pin(i_lock),
    .o_level(lock_s), .o_rise(), .o_fall());
  pin_sync u_rf (.i_clock(i_clock), .i_rst_n(rst_n_q), .i_pin(i_rf),
    .o_level(), .o_rise(rf_rise), .o_fall());
  pin_sync u_byp (.i_clock(i_clock), .i_rst_n(rst_n_q), .i_pin(i_bypass),
    .o_level(), .o_rise(byp_rise), .o_fall());

  // Mode decode; lock pin is only an input in tests 1 and 2
  mode_t mode;
  assign mode = !test_s ? M_NORMAL :
                en_s    ? M_TEST3  :
                lock_s  ? M_TEST1  : M_TEST2;

  logic is_norm;
  logic is_t12;
  logic is_t2;
  logic is_t3;
  assign is_norm = (mode == M_NORMAL);
  assign is_t12  = (mode == M_TEST1) || (mode == M_TEST2);
  assign is_t2   = (mode == M_TEST2);
  assign is_t3   = (mode == M_TEST3);

  // Software control
  logic [`CTRL_W-1:0] ctrl_q;   // Word length and reference step
  logic               long_w;   // 19-bit word, 10-bit main preset
  logic               fine_w;   // Divide reference by 2^10
  assign long_w = ctrl_q[`CTRL_LONG_BIT];
  assign fine_w = ctrl_q[`CTRL_FINE_BIT];

  // Serial shifter: only listens in normal mode
  logic [`SWORD_W-1:0] sh_q;
  logic                shift_ev;
  logic                load_ev;
  assign shift_ev = is_norm && en_s && sclk_rise;
  assign load_ev  = is_norm && en_fall;

  // Field split; a short word leaves the main MSB at zero
  logic [`BAND_W-1:0] w_band;
  logic [`MAIN_W-1:0] w_main;
  logic [`SWAL_W-1:0] w_swal;
  assign w_band = long_w ? sh_q[`BAND_LSB_LONG +: `BAND_W]
                         : sh_q[`BAND_LSB_SHORT +: `BAND_W];
  assign w_main = long_w ? sh_q[`MAIN_LSB +: `MAIN_W]
                         : {1'b0, sh_q[`MAIN_LSB +: `MAIN_W_SHORT]};
  assign w_swal = sh_q[`SWAL_LSB +: `SWAL_W];

  logic [`BAND_W-1:0] band_q;   // Band switch latches
  logic [`MAIN_W-1:0] main_q;   // Main preset
  logic [`SWAL_W-1:0] swal_p_q; // Swallow preset

  // MSB first: each new bit enters at the bottom
  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
      sh_q <= '0;
    else if (shift_ev)
      sh_q <= {sh_q[`SWORD_W-2:0], sdata_s};
  end

  // Presets change only when enable drops, never mid-word
  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      band_q   <= '0;
      main_q   <= '0;
      swal_p_q <= '0;
    end
    else if (load_ev)
    begin
      band_q   <= w_band;
      main_q   <= w_main;
      swal_p_q <= w_swal;
    end
  end
  assign o_band = band_q;

  // Reference divider; the clock stands in for the crystal
  logic [`REF_W-1:0] ref_cnt_q;
  logic [`REF_W-1:0] ref_last;
  logic              ref_tick;
  logic              ref_sq;
  assign ref_last = fine_w ? `REF_LAST_FINE : `REF_LAST_STD;
  assign ref_tick = (ref_cnt_q == ref_last);
  assign ref_sq   = fine_w ? ref_cnt_q[`REF_MSB_FINE]
                           : ref_cnt_q[`REF_MSB_STD];

  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
      ref_cnt_q <= '0;
    else if (ref_tick)
      ref_cnt_q <= '0;
    else
      ref_cnt_q <= ref_cnt_q + 1'b1;
  end

  // RF counter: low bits are the /8 prescaler, MSB the /256 tap
  logic [`RF_CNT_W-1:0] rf_cnt_q;
  logic                 rf_ev;
  logic                 pre_ev;
  assign rf_ev  = rf_rise && !is_t2;
  assign pre_ev = rf_ev && (rf_cnt_q[2:0] == `PRE_LAST);

  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
      rf_cnt_q <= '0;
    else if (rf_ev)
      rf_cnt_q <= rf_cnt_q + 1'b1;
  end

  // Divider input: bypass pin in test 2, prescaler otherwise
  logic chain_ev;
  assign chain_ev = is_t2 ? byp_rise : pre_ev;

  // Dual modulus stage with swallow and main counters
  logic [`MOD_W-1:0]  mod_cnt_q;
  logic [`SWAL_W-1:0] swal_q;
  logic [`MAIN_W-1:0] main_cnt_q;
  logic [`MAIN_W-1:0] main_end;
  logic [`MOD_W-1:0]  mod_last;
  logic               mod_wrap;
  logic               main_wrap;
  logic               main_sq_q;  // Main counter output, square
  assign mod_last  = (swal_q != '0) ? `MOD_LAST_33
                                    : `MOD_LAST_32;
  assign mod_wrap  = chain_ev && (mod_cnt_q == mod_last);
  assign main_end  = main_q - 1'b1;
  assign main_wrap = mod_wrap && (main_cnt_q == main_end);

  // A preset load restarts the chain from a clean cycle
  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      mod_cnt_q  <= '0;
      swal_q     <= '0;
      main_cnt_q <= '0;
      main_sq_q  <= 1'b0;
    end
    else if (load_ev)
    begin
      mod_cnt_q  <= '0;
      swal_q     <= w_swal;
      main_cnt_q <= '0;
    end
    else if (main_wrap)
    begin
      mod_cnt_q  <= '0;
      swal_q     <= swal_p_q;
      main_cnt_q <= '0;
      main_sq_q  <= ~main_sq_q;
    end
    else if (mod_wrap)
    begin
      mod_cnt_q  <= '0;
      main_cnt_q <= main_cnt_q + 1'b1;
      if (swal_q != '0)
        swal_q <= swal_q - 1'b1;
    end
    else if (chain_ev)
      mod_cnt_q <= mod_cnt_q + 1'b1;
  end

  // Comparator inputs: external pins in test 3
  logic ref_ev;
  logic div_ev;
  assign ref_ev = is_t3 ? sclk_rise  : ref_tick;
  assign div_ev = is_t3 ? sdata_rise : main_wrap;

  // Phase-frequency detector: first edge opens a pump pulse
  logic              up_q;
  logic              dn_q;
  logic              up_set;
  logic              dn_set;
  logic              both;
  logic [`ERR_W-1:0] err_q;   // Length of the open pulse
  logic              lock_q;
  logic              lock_now;
  assign up_set   = up_q | div_ev;
  assign dn_set   = dn_q | ref_ev;
  assign both     = up_set & dn_set;
  assign lock_now = (err_q <= `LOCK_WIN);

  // Lock judged once per comparison, on pulse width
  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      up_q   <= 1'b0;
      dn_q   <= 1'b0;
      err_q  <= '0;
      lock_q <= 1'b0;
    end
    else
    begin
      up_q <= up_set & ~both;
      dn_q <= dn_set & ~both;
      if (both)
      begin
        err_q  <= '0;
        lock_q <= lock_now;
      end
      else if ((up_q | dn_q) && (err_q != '1))
        err_q <= err_q + 1'b1;  // Saturates, never wraps to locked
    end
  end

  // Faster input pumps high, slower pumps low, else released
  assign o_pump      = up_q;
  assign o_pump_oe_n = ~(up_q | dn_q);

  // Pin drivers, registered so pins never glitch on decode
  logic sclk_q;
  logic sclk_oe_n_q;
  logic sdata_q;
  logic sdata_oe_n_q;
  logic lock_o_q;
  logic lock_oe_n_q;

  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      sclk_q       <= 1'b0;
      sclk_oe_n_q  <= 1'b1;
      sdata_q      <= 1'b0;
      sdata_oe_n_q <= 1'b1;
      lock_o_q     <= 1'b0;
      lock_oe_n_q  <= 1'b1;
    end
    else
    begin
      sclk_q       <= ref_sq;
      sclk_oe_n_q  <= ~is_t12;
      sdata_q      <= main_sq_q;
      sdata_oe_n_q <= ~is_t12;
      lock_o_q     <= is_t3 & rf_cnt_q[`RF_TAP_256];
      lock_oe_n_q  <= ~(is_t3 | (is_norm & lock_q));
    end
  end
  assign o_sclk       = sclk_q;
  assign o_sclk_oe_n  = sclk_oe_n_q;
  assign o_sdata      = sdata_q;
  assign o_sdata_oe_n = sdata_oe_n_q;
  assign o_lock       = lock_o_q;
  assign o_lock_oe_n  = lock_oe_n_q;

  // AXI4-Lite: address and data are taken together
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        wr_go;
  logic        rd_go;
  logic        wr_hit;
  logic        rd_hit;
  assign wr_go     = i_awvalid & i_wvalid & ~bvalid_q;
  assign rd_go     = i_arvalid & ~rvalid_q;
  assign o_awready = wr_go;
  assign o_wready  = wr_go;
  assign o_arready = rd_go;
  assign wr_hit = (i_awaddr == `CTRL_ADDR) || (i_awaddr == `STAT_ADDR) ||
                  (i_awaddr == `PRESET_ADDR) ||
                  (i_awaddr == `IRQ_STAT_ADDR) ||
                  (i_awaddr == `IRQ_CLR_ADDR) || (i_awaddr == `IRQ_EN_ADDR);
  assign rd_hit = (i_araddr == `CTRL_ADDR) || (i_araddr == `STAT_ADDR) ||
                  (i_araddr == `PRESET_ADDR) ||
                  (i_araddr == `IRQ_STAT_ADDR) ||
                  (i_araddr == `IRQ_CLR_ADDR) || (i_araddr == `IRQ_EN_ADDR);

  // Only byte lane 0 carries control bits
  logic wr_lane0;
  logic wr_ctrl;
  logic wr_clr;
  logic wr_en;
  assign wr_lane0 = wr_go & i_wstrb[0];
  assign wr_ctrl  = wr_lane0 && (i_awaddr == `CTRL_ADDR);
  assign wr_clr   = wr_lane0 && (i_awaddr == `IRQ_CLR_ADDR);
  assign wr_en    = wr_lane0 && (i_awaddr == `IRQ_EN_ADDR);

  // Interrupt events; a new event beats a same-cycle clear
  logic [`IRQ_W-1:0] irq_stat_q;
  logic [`IRQ_W-1:0] irq_en_q;
  logic [`IRQ_W-1:0] irq_ev;
  logic [`IRQ_W-1:0] irq_clr;
  assign irq_ev  = {both & lock_q & ~lock_now,
                    both & ~lock_q & lock_now,
                    load_ev};
  assign irq_clr = wr_clr ? i_wdata[`IRQ_W-1:0] : '0;
  assign o_irq   = |(irq_stat_q & irq_en_q);

  // Register writes and the write response
  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      ctrl_q     <= `CTRL_RST;
      irq_en_q   <= `IRQ_RST;
      irq_stat_q <= `IRQ_RST;
      bvalid_q   <= 1'b0;
      bresp_q    <= `RESP_OKAY;
    end
    else
    begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
      if (wr_ctrl)
        ctrl_q <= i_wdata[`CTRL_W-1:0];
      if (wr_en)
        irq_en_q <= i_wdata[`IRQ_W-1:0];
      if (wr_go)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (i_bready)
        bvalid_q <= 1'b0;
    end
  end
  assign o_bvalid = bvalid_q;
  assign o_bresp  = bresp_q;

  // Read data words; status shows the live loop state
  logic [31:0] stat_word;
  logic [31:0] preset_word;
  logic [31:0] rd_word;
  assign stat_word   = {20'h0, band_q, 3'h0, lock_q, dn_q, up_q, mode};
  assign preset_word = {11'h0, main_q, 6'h0, swal_p_q};
  assign rd_word =
    (i_araddr == `CTRL_ADDR)     ? {30'h0, ctrl_q}     :
    (i_araddr == `STAT_ADDR)     ? stat_word           :
    (i_araddr == `PRESET_ADDR)   ? preset_word         :
    (i_araddr == `IRQ_STAT_ADDR) ? {29'h0, irq_stat_q} :
    (i_araddr == `IRQ_EN_ADDR)   ? {29'h0, irq_en_q}   : 32'h0;

  // Read answer one cycle after the address is taken
  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= `RESP_OKAY;
    end
    else if (rd_go)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (i_rready)
      rvalid_q <= 1'b0;
  end
  assign o_rvalid = rvalid_q;
  assign o_rdata  = rdata_q;
  assign o_rresp  = rresp_q;

  // Checks on the mode, divider and pin behaviour
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!rst_n_q);

  property p_normal;
    !test_s |=> (o_sclk_oe_n && o_sdata_oe_n);
  endproperty
  a_normal: assert property (p_normal)
    else $error("test low but a serial pin is driven");

  property p_ref_out;
    is_t12 |=> (!o_sclk_oe_n && !o_sdata_oe_n && o_sclk == $past(ref_sq));
  endproperty
  a_ref_out: assert property (p_ref_out)
    else $error("reference not driven on clock pin");

  property p_rf_path;
    (mode == M_TEST1) |-> (chain_ev == pre_ev);
  endproperty
  a_rf_path: assert property (p_rf_path)
    else $error("test 1 chain not fed from prescaler");

  property p_bypass;
    is_t2 |-> (chain_ev == byp_rise) && !rf_ev;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("test 2 divider input wrong");

  property p_tap256;
    is_t3 |=> (!o_lock_oe_n && o_lock == $past(rf_cnt_q[`RF_TAP_256]));
  endproperty
  a_tap256: assert property (p_tap256)
    else $error("lock pin not showing divided RF");

  property p_pump;
    (div_ev && !ref_ev && !up_q && !dn_q) |=> (o_pump && !o_pump_oe_n);
  endproperty
  a_pump: assert property (p_pump)
    else $error("pump not high for fast input");

  property p_ref_wrap;
    ref_tick |=> (ref_cnt_q == '0) ##1 (ref_cnt_q == 10'h001);
  endproperty
  a_ref_wrap: assert property (p_ref_wrap)
    else $error("reference counter did not wrap");

  property p_swallow;
    (main_wrap && !load_ev) |=> (swal_q == $past(swal_p_q)) &&
                                (main_cnt_q == '0) && (mod_cnt_q == '0);
  endproperty
  a_swallow: assert property (p_swallow)
    else $error("swallow not reloaded at main wrap");

  property p_lock_rel;
    (is_norm && !lock_q) |=> o_lock_oe_n;
  endproperty
  a_lock_rel: assert property (p_lock_rel)
    else $error("lock pin pulled while unlocked");

  property p_load;
    load_ev |=> (o_band == $past(w_band)) && (main_q == $past(w_main));
  endproperty
  a_load: assert property (p_load)
    else $error("word not transferred at enable end");

  property p_shift;
    shift_ev |=> (sh_q[0] == $past(sdata_s));
  endproperty
  a_shift: assert property (p_shift)
    else $error("serial bit not shifted in");

endmodule

// ---- tb/ctrl_host.sv ----
// Controller side of the three-wire serial link
module ctrl_host
(
  input  wire logic i_clock,
  output logic      o_load_en,
  output logic      o_sclk,
  output logic      o_sdata
);
  timeunit 1ns;
  timeprecision 1ns;

  logic busy; // Frame in progress

  initial
  begin
    o_load_en = 1'b0;
    o_sclk    = 1'b0;
    o_sdata   = 1'b0;
    busy      = 1'b0;
  end

  // Released data line keeps changing, so a stale bit never passes as data
  always @(posedge i_clock)
    if (!busy)
      o_sdata <= ~o_sdata;

  // One frame: n bits, MSB first; 4 clocks per phase beats the 3 needed
  task automatic send(input logic [18:0] w, input int n);
    busy = 1'b1;
    @(posedge i_clock);
    o_load_en <= 1'b1;
    for (int i = n - 1; i >= 0; i--)
    begin
      @(posedge i_clock);
      o_sdata <= w[i];
      repeat (4) @(posedge i_clock);
      o_sclk <= 1'b1;
      repeat (4) @(posedge i_clock);
      o_sclk <= 1'b0;
    end
    repeat (4) @(posedge i_clock);
    o_load_en <= 1'b0;
    repeat (4) @(posedge i_clock);
    busy = 1'b0;
  endtask
endmodule

// ---- tb/testbench.sv ----
`include "synth_map.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clock = 1'b0;
  logic        rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic        test_sel, tb_en, tb_sclk, tb_sdata, lock_lvl;
  logic        h_en, h_sclk, h_sdata, sclk_o, sclk_oe_n, sdata_o;
  logic        sdata_oe_n, lock_o, lock_oe_n, pump, pump_oe_n;
  logic [3:0]  band;
  wire         en_pin, sclk_pin, sdata_pin, lock_pin;
  int          n_errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  logic        rf_on = 1'b0, byp_on = 1'b0, rf_in = 1'b0, byp_in = 1'b0;

  // RF and bypass sources: one rise every second clock while switched on
  always @(posedge clock)
  begin
    rf_in  <= rf_on & ~rf_in;
    byp_in <= byp_on & ~byp_in;
  end

  // Pin levels from every driver; the lock pin has a pull-up in normal use
  assign en_pin    = test_sel ? tb_en : h_en;
  assign sclk_pin  = sclk_oe_n ? (test_sel ? tb_sclk : h_sclk) : sclk_o;
  assign sdata_pin = sdata_oe_n ? (test_sel ? tb_sdata : h_sdata) : sdata_o;
  assign lock_pin  = lock_oe_n ? lock_lvl : lock_o;

  synth_core synth_core_inst (.i_clock(clock), .i_rst_n(rst_n),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'hf),
    .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
    .i_test_sel(test_sel), .i_load_en(en_pin), .i_sclk(sclk_pin),
    .o_sclk(sclk_o), .o_sclk_oe_n(sclk_oe_n), .i_sdata(sdata_pin),
    .o_sdata(sdata_o), .o_sdata_oe_n(sdata_oe_n), .i_lock(lock_pin),
    .o_lock(lock_o), .o_lock_oe_n(lock_oe_n), .i_rf(rf_in), .i_bypass(byp_in),
    .o_pump(pump), .o_pump_oe_n(pump_oe_n), .o_band(band), .o_irq(irq));

  ctrl_host ctrl_host_inst (.i_clock(clock), .o_load_en(h_en),
    .o_sclk(h_sclk), .o_sdata(h_sdata));

  always #25 clock = ~clock;

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Hang guard: the whole run needs about 10600 cycles
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Write; addresses past the map answer with an error response
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic       ok;
    logic [1:0] r;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    awaddr  <= a;
    wdata   <= d;
    bready  <= 1'b1;
    ok = 1'b0;
    while (!ok)
    begin
      @(negedge clock);
      ok = awready & wready;
      @(posedge clock);
    end
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    ok = 1'b0;
    while (!ok)
    begin
      @(negedge clock);
      ok = bvalid;
      r  = bresp;
      @(posedge clock);
    end
    bready <= 1'b0;
    @(posedge clock); // Idle edge so the next call never re-raises bready
    check("bresp", {30'h0, r}, (a > 8'h14) ? 32'h2 : 32'h0);
  endtask

  // Read and compare the masked word
  task automatic rd(input logic [7:0] a, input logic [31:0] m, exp);
    logic        ok;
    logic [1:0]  r;
    logic [31:0] d;
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    ok = 1'b0;
    while (!ok)
    begin
      @(negedge clock);
      ok = arready;
      @(posedge clock);
    end
    arvalid <= 1'b0;
    ok = 1'b0;
    while (!ok)
    begin
      @(negedge clock);
      ok = rvalid;
      r  = rresp;
      d  = rdata;
      @(posedge clock);
    end
    rready <= 1'b0;
    @(posedge clock); // Idle edge so the next call never re-raises rready
    check("rresp", {30'h0, r}, (a > 8'h14) ? 32'h2 : 32'h0);
    check("rdata", d & m, exp);
  endtask

  // Reference period in clocks, rise to rise, after one settling period
  task automatic ref_period(input int exp);
    realtime t0;
    @(posedge sclk_o);
    @(posedge sclk_o);
    t0 = $realtime;
    @(posedge sclk_o);
    check("ref", 32'(int'(($realtime - t0) / 50.0)), exp);
  endtask

  // High time in clocks of the main counter output or the lock pin
  task automatic high_time(input bit use_lock, input int exp);
    realtime t0;
    if (use_lock)
      @(posedge lock_o);
    else
      @(posedge sdata_o);
    t0 = $realtime;
    if (use_lock)
      @(negedge lock_o);
    else
      @(negedge sdata_o);
    check("high", 32'(int'(($realtime - t0) / 50.0)), exp);
  endtask

  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata} = 48'h0;
    {test_sel, tb_en, tb_sclk, tb_sdata} = 4'h0;
    lock_lvl = 1'b1;
    rst_n = 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    // Reset values and an unmapped place
    rd(`CTRL_ADDR, 32'hffffffff, 32'h0);
    rd(`IRQ_EN_ADDR, 32'hffffffff, 32'h0);
    rd(8'h18, 32'hffffffff, 32'h0);
    wr(8'h18, 32'h1);
    $display("test 1 done");
    // Short word, example tuning value; completion interrupt enabled
    wr(`IRQ_EN_ADDR, 32'h1);
    ctrl_host_inst.send({1'b0, 4'h8, 9'd400, 5'd16}, 18);
    check("band", {28'h0, band}, 32'h8);
    rd(`PRESET_ADDR, 32'hffffffff, (32'd400 << 11) | 32'd16);
    check("irq", {31'h0, irq}, 32'h1);
    wr(`IRQ_CLR_ADDR, 32'h1);
    check("irq", {31'h0, irq}, 32'h0);
    check("lock_oe_n", {31'h0, lock_oe_n}, 32'h1);
    $display("test 2 done");
    // Long word with interrupt masked; status stays sticky
    wr(`IRQ_EN_ADDR, 32'h0);
    wr(`CTRL_ADDR, 32'h1);
    ctrl_host_inst.send({4'h5, 10'd1023, 5'd31}, 19);
    check("band", {28'h0, band}, 32'h5);
    rd(`PRESET_ADDR, 32'hffffffff, (32'd1023 << 11) | 32'd31);
    check("irq", {31'h0, irq}, 32'h0);
    rd(`IRQ_STAT_ADDR, 32'h1, 32'h1);
    // Smallest main preset, one swallow cycle, for the divider tests
    ctrl_host_inst.send({4'h1, 10'd32, 5'd1}, 19);
    check("band", {28'h0, band}, 32'h1);
    $display("test 3 done");
    // Each test mode from pin levels, with pin directions
    for (int m = 1; m <= 3; m++)
    begin
      if (m == 2)
        wr(`CTRL_ADDR, 32'h3);
      test_sel <= 1'b1;
      tb_en    <= (m == 3);
      lock_lvl <= (m == 1);
      byp_on   <= (m == 2);
      rf_on    <= (m == 3);
      repeat (6) @(posedge clock);
      rd(`STAT_ADDR, 32'h3, 32'(m));
      check("sclk_oe_n", {31'h0, sclk_oe_n}, 32'(m == 3));
      check("sdata_oe_n", {31'h0, sdata_oe_n}, 32'(m == 3));
      check("lock_oe_n", {31'h0, lock_oe_n}, 32'(m != 3));
      if (m < 3)
        ref_period(m * 512);
      if (m == 2)
        high_time(1'b0, 2 * (32 * 32 + 1));
      if (m == 3)
        high_time(1'b1, 256);
    end
    $display("test 4 done");
    // The last test 2 main wrap closes the reference pulse; both edges only make a zero-width comparison
    tb_sclk  <= 1'b1;
    tb_sdata <= 1'b1;
    repeat (6) @(posedge clock);
    tb_sclk  <= 1'b0;
    tb_sdata <= 1'b0;
    repeat (6) @(posedge clock);
    // Comparator in mode 3: compared edge first, then reference first
    tb_sdata <= 1'b1;
    repeat (6) @(posedge clock);
    check("pump", {30'h0, pump_oe_n, pump}, 32'h1);
    tb_sclk <= 1'b1;
    repeat (6) @(posedge clock);
    check("pump_oe_n", {31'h0, pump_oe_n}, 32'h1);
    tb_sclk  <= 1'b0;
    tb_sdata <= 1'b0;
    repeat (6) @(posedge clock);
    tb_sclk <= 1'b1;
    repeat (6) @(posedge clock);
    check("pump", {30'h0, pump_oe_n, pump}, 32'h0);
    $display("test 5 done");
    end_of_test();
  end
endmodule
